// ---- dv/rcs_top_properties.sv ----
// port-level checker of the reset-cause block, bound to its top
`timescale 1ns/10ps
module rcs_chk #(
  parameter HAS_BOR = 1,
  parameter POWERUP_TIMER_CYCLES = 20
) (
  // clock, reset, bus
  input wire I_MCLK,
  input wire I_SYS_RST,
  input wire I_RD,
  // sources and configuration
  input wire I_MASTER_CLEAR_PIN_N,
  input wire I_BROWNOUT_DET,
  input wire I_BROWNOUT_ENABLE_CFG,
  input wire I_POWERUP_TIMER_ENABLE_CFG,
  input wire [1:0] I_OSC_MODE,
  // outputs watched
  input wire [7:0] O_RDATA,
  input wire O_CPU_HOLD,
  input wire O_PERIPH_RESET,
  input wire O_ASLEEP,
  input wire O_PC_LOAD,
  input wire [12:0] O_PC_VALUE,
  input wire O_TIMEOUT_FLAG,
  input wire O_POWERDOWN_FLAG
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  // =====================================================
  // assertions
  pc_load_pulse_a: assert property (O_PC_LOAD |=> !O_PC_LOAD)
    else $error("pc load longer than one cycle");
  hold_release_a: assert property ($fell(O_CPU_HOLD) |-> O_PC_LOAD)
    else $error("core released without pc load");
  rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read answer");
  periph_in_hold_a: assert property (O_PERIPH_RESET |-> O_CPU_HOLD)
    else $error("peripheral reset while core runs");
  por_flags_set_a: assert property ($fell(I_SYS_RST) |->
    O_TIMEOUT_FLAG && O_POWERDOWN_FLAG && O_CPU_HOLD)
    else $error("power-on flags wrong");
  powerup_timer_hold_a: assert property ($fell(I_SYS_RST) && I_OSC_MODE == 2'h3 &&
    I_POWERUP_TIMER_ENABLE_CFG == (HAS_BOR == 0) |-> O_CPU_HOLD [*8])
    else $error("power-up timer hold too short");
  reset_vector_a: assert property (O_PC_LOAD && O_POWERDOWN_FLAG |->
    O_PC_VALUE == 13'h0000)
    else $error("reset restart not at zero");
  brownout_hold_a: assert property ((HAS_BOR != 0) && I_BROWNOUT_ENABLE_CFG &&
    I_BROWNOUT_DET |-> ##[1:4] O_PERIPH_RESET)
    else $error("brown-out did not reset");
  master_clear_pin_hold_a: assert property (!I_MASTER_CLEAR_PIN_N [*5] |-> O_CPU_HOLD)
    else $error("core runs with master clear low");
  // =====================================================
  // covers
  irq_vec_c: cover property (O_PC_LOAD && O_PC_VALUE == 13'h0004);
  sleep_c: cover property ($rose(O_ASLEEP));
  brownout_c: cover property ($fell(I_BROWNOUT_DET));
endmodule // rcs_chk
bind rcs_top rcs_chk #(.HAS_BOR(HAS_BOR), .POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) u_chk (.I_MCLK(I_MCLK),
  .I_SYS_RST(I_SYS_RST), .I_RD(I_RD), .I_MASTER_CLEAR_PIN_N(I_MASTER_CLEAR_PIN_N),
  .I_BROWNOUT_DET(I_BROWNOUT_DET), .I_BROWNOUT_ENABLE_CFG(I_BROWNOUT_ENABLE_CFG),
  .I_POWERUP_TIMER_ENABLE_CFG(I_POWERUP_TIMER_ENABLE_CFG), .I_OSC_MODE(I_OSC_MODE),
  .O_RDATA(O_RDATA), .O_CPU_HOLD(O_CPU_HOLD), .O_PERIPH_RESET(O_PERIPH_RESET),
  .O_ASLEEP(O_ASLEEP), .O_PC_LOAD(O_PC_LOAD), .O_PC_VALUE(O_PC_VALUE),
  .O_TIMEOUT_FLAG(O_TIMEOUT_FLAG), .O_POWERDOWN_FLAG(O_POWERDOWN_FLAG));

// ---- dv/rcs_top_tb.sv ----
// self-checking bench of the reset-cause block
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module rcs_top_tb;
  localparam int P = 20;
  localparam int O = 8;
  // =====================================================
  // signals
  logic clk = 0, rst = 1, wr = 0, rd = 0, master_clear_pin_n = 1, bod = 0, wdt = 0, irqw = 0;
  logic global_irq_enable = 0, brownout_enable_cfg = 1, powerup_timer_enable_cfg = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [12:0] pc_in = 13'h0123, pcv;
  logic [1:0] osc = 2'h3;
  logic hold, prst, asleep, pcl, tof, pdf, irq;
  int errors = 0, cmp_count = 0, cyc = 0, n = 0;
  int md[5] = '{3, 3, 1, 2, 0};
  int pe[5] = '{0, 1, 0, 1, 0};
  int lo[5] = '{P, 0, P + O, O, P + O};
  rcs_top #(.HAS_BOR(1), .POWERUP_TIMER_CYCLES(25'd20), .OST_CYCLES(25'd8)) u_dut (
    .I_MCLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n), .I_BROWNOUT_DET(bod),
    .I_WATCHDOG_TIMER_EXPIRE(wdt), .I_IRQ_WAKE(irqw), .I_GLOBAL_IRQ_ENABLE(global_irq_enable),
    .I_PC(pc_in), .I_OSC_MODE(osc), .I_BROWNOUT_ENABLE_CFG(brownout_enable_cfg),
    .I_POWERUP_TIMER_ENABLE_CFG(powerup_timer_enable_cfg), .O_CPU_HOLD(hold), .O_PERIPH_RESET(prst),
    .O_ASLEEP(asleep), .O_PC_LOAD(pcl), .O_PC_VALUE(pcv), .O_TIMEOUT_FLAG(tof),
    .O_POWERDOWN_FLAG(pdf), .O_IRQ(irq));
  // =====================================================
  // clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end
  // =====================================================
  // tasks
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // count edges until the restart pulse
  task wait_pc;
    n = 0;
    @(posedge clk);
    #1;
    while (pcl !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (pcl !== 1'b1) errors++;
  endtask
  task por(input logic [1:0] m, input logic p);
    @(posedge clk);
    rst <= 1'b1;
    osc <= m;
    powerup_timer_enable_cfg <= p;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_pc();
  endtask
  // enter sleep, wake by irq (0), watchdog (1) or master clear (2)
  task sleep_wake(input int src);
    bus_wr(8'h04, 8'h01);
    repeat (3) @(posedge clk);
    #1 `CHK(asleep, 1'b1)
    @(posedge clk);
    if (src == 2) master_clear_pin_n <= 1'b0;
    else if (src == 1) wdt <= 1'b1;
    else irqw <= 1'b1;
    repeat (src == 2 ? 6 : 1) @(posedge clk);
    master_clear_pin_n <= 1'b1;
    wdt <= 1'b0;
    irqw <= 1'b0;
    wait_pc();
  endtask
  // =====================================================
  // main sequence
  initial begin
    for (int i = 0; i < 5; i++) begin
      por(md[i][1:0], pe[i][0]);
      `CHK(n >= lo[i] && n <= lo[i] + 10, 1'b1)
      bus_rd(8'h01, 8'h18);
      bus_rd(8'h00, 8'h00);
      bus_rd(8'h02, 8'h01);
      $display("power-up row %0d done", i);
    end
    bus_rd(8'h7f, 8'h00);
    bus_wr(8'h00, 8'hff);
    bus_rd(8'h00, 8'h03);
    bus_wr(8'h03, 8'h04);
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    master_clear_pin_n <= 1'b1;
    wait_pc();
    `CHK(pcv, 13'h0000)
    `CHK(irq, 1'b1)
    bus_rd(8'h02, 8'h04);
    `CHK(irq, 1'b0)
    bus_rd(8'h01, 8'h18);
    bus_rd(8'h00, 8'h03);
    $display("master clear awake done");
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    wait_pc();
    `CHK(pcv, 13'h0000)
    bus_rd(8'h01, 8'h08);
    @(posedge clk) global_irq_enable <= 1'b1;
    sleep_wake(0);
    `CHK(n >= O, 1'b1)
    `CHK(pcv, 13'h0004)
    bus_rd(8'h01, 8'h10);
    @(posedge clk) global_irq_enable <= 1'b0;
    sleep_wake(0);
    `CHK(pcv, 13'h0124)
    sleep_wake(2);
    `CHK(pcv, 13'h0000)
    bus_rd(8'h01, 8'h10);
    sleep_wake(1);
    `CHK(pcv, 13'h0124)
    bus_rd(8'h01, 8'h00);
    bus_rd(8'h00, 8'h03);
    $display("sleep and wake done");
    @(posedge clk);
    bod <= 1'b1;
    repeat (5) @(posedge clk);
    bod <= 1'b0;
    repeat (10) @(posedge clk);
    bod <= 1'b1;
    repeat (5) @(posedge clk);
    bod <= 1'b0;
    wait_pc();
    `CHK(n >= P + O, 1'b1)
    `CHK(pcv, 13'h0000)
    bus_rd(8'h00, 8'h02);
    bus_rd(8'h01, 8'h18);
    $display("brown-out done");
    @(posedge clk) brownout_enable_cfg <= 1'b0;
    bod <= 1'b1;
    repeat (6) @(posedge clk);
    bod <= 1'b0;
    #1 `CHK(hold, 1'b0)
    $display("brown-out disabled done");
    summarize();
  end
endmodule // rcs_top_tb

// ---- rtl/rcs_delay.v ----
// down-counting delay timer shared by the power-up and oscillator start-up waits
`timescale 1ns/10ps
module rcs_delay #(
  parameter W = 25
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // control
  input wire i_start,
  input wire i_abort,
  input wire [W-1:0] i_len,
  // status
  output wire o_busy,
  output wire o_done
);

  reg [W-1:0] cnt_q;
  reg busy_q;

  // =====================================================
  // counter
  // load length minus one, count to zero, then stop
  always @(posedge i_clk) begin
    if (i_rst || i_abort) begin
      cnt_q <= {W{1'b0}};
      busy_q <= 1'b0;
    end else if (i_start) begin
      cnt_q <= i_len - {{(W-1){1'b0}}, 1'b1};
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == {W{1'b0}}) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // done in the last counted cycle
  assign o_busy = busy_q;
  assign o_done = busy_q && (cnt_q == {W{1'b0}}) && !i_abort;

endmodule // rcs_delay

// ---- rtl/rcs_map.vh ----
// register map, field positions, reset values and timing counts of the reset-cause block
`ifndef RCS_MAP_VH
`define RCS_MAP_VH

// =====================================================
// register offsets
`define RCS_ADDR_PWR_STAT 8'h00
`define RCS_ADDR_RST_FLAGS 8'h01
`define RCS_ADDR_EVT_STAT 8'h02
`define RCS_ADDR_EVT_MASK 8'h03
`define RCS_ADDR_SLEEP_CTL 8'h04

// =====================================================
// field positions
`define RCS_PWR_BOR_BIT 0
`define RCS_PWR_POR_BIT 1
`define RCS_FLG_PD_BIT 3
`define RCS_FLG_TO_BIT 4
`define RCS_SLEEP_GO_BIT 0
`define RCS_EVT_POR_BIT 0
`define RCS_EVT_BOR_BIT 1
`define RCS_EVT_MASTER_CLEAR_PIN_BIT 2
`define RCS_EVT_WDT_BIT 3
`define RCS_EVT_WAKE_BIT 4
`define RCS_EVT_W 5

// =====================================================
// reset values
`define RCS_POR_FLAG_RST 1'b0
`define RCS_BOR_FLAG_RST 1'b0
`define RCS_TO_FLAG_RST 1'b1
`define RCS_PD_FLAG_RST 1'b1
`define RCS_EVT_MASK_RST 5'h00

// =====================================================
// oscillator mode codes
`define RCS_OSC_LP 2'h0
`define RCS_OSC_XT 2'h1
`define RCS_OSC_HS 2'h2
`define RCS_OSC_RC 2'h3

// =====================================================
// program counter targets
`define RCS_PC_RESET 13'h0000
`define RCS_PC_IRQ_VEC 13'h0004

// =====================================================
// timing
`define RCS_CLK_KHZ 250000
`define RCS_POWERUP_TIMER_MS 72
`define RCS_POWERUP_TIMER_CYCLES 25'd18000000 // 72 ms of the 250 MHz clock, sized for the timer
`define RCS_OST_PERIODS 25'd1024
`define RCS_TMR_W 25

`endif

// ---- rtl/rcs_top.v ----
// reset-cause flags, start-up time-outs and restart vector selection
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "rcs_map.vh"
module rcs_top #(
  parameter HAS_BOR = 1,
  parameter [`RCS_TMR_W-1:0] POWERUP_TIMER_CYCLES = `RCS_POWERUP_TIMER_CYCLES,
  parameter [`RCS_TMR_W-1:0] OST_CYCLES = `RCS_OST_PERIODS
) (
  // clock and reset
  input wire I_MCLK,
  input wire I_SYS_RST,
  // register port
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  // reset sources
  input wire I_MASTER_CLEAR_PIN_N,
  input wire I_BROWNOUT_DET,
  input wire I_WATCHDOG_TIMER_EXPIRE,
  input wire I_IRQ_WAKE,
  input wire I_GLOBAL_IRQ_ENABLE,
  input wire [12:0] I_PC,
  // configuration word
  input wire [1:0] I_OSC_MODE,
  input wire I_BROWNOUT_ENABLE_CFG,
  input wire I_POWERUP_TIMER_ENABLE_CFG,
  // core control
  output wire O_CPU_HOLD,
  output wire O_PERIPH_RESET,
  output wire O_ASLEEP,
  output reg O_PC_LOAD,
  output reg [12:0] O_PC_VALUE,
  output wire O_TIMEOUT_FLAG,
  output wire O_POWERDOWN_FLAG,
  output wire O_IRQ
);

  // =====================================================
  // states and reset reasons
  localparam [2:0] ST_ARM = 3'h0, ST_POWERUP_TIMER = 3'h1, ST_OST = 3'h2, ST_FIN = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4, ST_RUN = 3'h5, ST_SLEEP = 3'h6;
  localparam [1:0] WHY_POR = 2'h0, WHY_BOR = 2'h1, WHY_CLR = 2'h2, WHY_WAKE = 2'h3;

  reg [2:0] state_q, state_d;
  reg [1:0] why_q, why_d;
  reg [12:0] pc_tgt_q, pc_tgt_d;
  reg por_flag_q, bor_flag_q, to_flag_q, pd_flag_q;
  reg [`RCS_EVT_W-1:0] evt_q, mask_q;
  reg master_clear_pin_m_q, master_clear_pin_s_q, bod_m_q, bod_s_q, master_clear_pin_low_q;
  reg tmr_start, tmr_abort, pc_load_d;
  reg [`RCS_TMR_W-1:0] tmr_len;
  wire tmr_busy, tmr_done, crystal, powerup_timer_en, bod_live, master_clear_pin_fall;
  wire wr_pwr, wr_mask, rd_evt, sleep_go;
  reg ev_bor, ev_master_clear_pin, ev_wdt_rst, ev_wake, ev_master_clear_pin_slp, ev_irq_wake, ev_wdt_wake;

  // =====================================================
  // pin synchronisers
  // master clear pin and brown-out comparator are asynchronous
  always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      master_clear_pin_m_q <= 1'b1;
      master_clear_pin_s_q <= 1'b1;
      bod_m_q <= 1'b0;
      bod_s_q <= 1'b0;
      master_clear_pin_low_q <= 1'b0;
    end else begin
      master_clear_pin_m_q <= I_MASTER_CLEAR_PIN_N;
      master_clear_pin_s_q <= master_clear_pin_m_q;
      bod_m_q <= I_BROWNOUT_DET;
      bod_s_q <= bod_m_q;
      master_clear_pin_low_q <= !master_clear_pin_s_q;
    end
  end

  // falling edge of the synchronised pin
  assign master_clear_pin_fall = !master_clear_pin_s_q && !master_clear_pin_low_q;

  // =====================================================
  // configuration decode
  // no brown-out circuit on variants without it or when disabled
  assign bod_live = (HAS_BOR != 0) && I_BROWNOUT_ENABLE_CFG && bod_s_q;

  // start-up wait only for the three crystal or resonator modes
  assign crystal = (I_OSC_MODE != `RCS_OSC_RC);

  // enable polarity is inverted on brown-out variants
  assign powerup_timer_en = (HAS_BOR != 0) ^ I_POWERUP_TIMER_ENABLE_CFG;

  // =====================================================
  // register strobes
  assign wr_pwr = I_WR && (I_ADDR == `RCS_ADDR_PWR_STAT);
  assign wr_mask = I_WR && (I_ADDR == `RCS_ADDR_EVT_MASK);
  assign rd_evt = I_RD && (I_ADDR == `RCS_ADDR_EVT_STAT);
  assign sleep_go = I_WR && (I_ADDR == `RCS_ADDR_SLEEP_CTL) &&
                    I_WDATA[`RCS_SLEEP_GO_BIT] && (state_q == ST_RUN);

  // =====================================================
  // event classification
  // brown-out wins over master clear, which wins over watchdog
  always @* begin
    ev_bor = bod_live;
    ev_master_clear_pin = 1'b0;
    ev_master_clear_pin_slp = 1'b0;
    ev_wdt_rst = 1'b0;
    ev_wdt_wake = 1'b0;
    ev_irq_wake = 1'b0;
    if (!bod_live) begin
      if (state_q == ST_RUN) begin
        ev_master_clear_pin = master_clear_pin_fall;
        ev_wdt_rst = !master_clear_pin_fall && I_WATCHDOG_TIMER_EXPIRE;
      end else if (state_q == ST_SLEEP) begin
        ev_master_clear_pin_slp = master_clear_pin_fall;
        ev_wdt_wake = !master_clear_pin_fall && I_WATCHDOG_TIMER_EXPIRE;
        ev_irq_wake = !master_clear_pin_fall && !I_WATCHDOG_TIMER_EXPIRE && I_IRQ_WAKE;
      end
    end
    ev_wake = ev_wdt_wake || ev_irq_wake;
  end

  // =====================================================
  // sequencer
  always @* begin
    state_d = state_q;
    why_d = why_q;
    pc_tgt_d = pc_tgt_q;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_len = POWERUP_TIMER_CYCLES;
    pc_load_d = 1'b0;
    if (ev_bor) begin
      // stay in brown-out reset; a running power-up timer starts over
      if (state_q != ST_HOLD || why_q != WHY_BOR) begin
        state_d = ST_HOLD;
        why_d = WHY_BOR;
        tmr_abort = 1'b1;
      end
      pc_tgt_d = `RCS_PC_RESET;
    end else if (ev_master_clear_pin || ev_master_clear_pin_slp || ev_wdt_rst) begin
      state_d = ST_HOLD;
      why_d = WHY_CLR;
      pc_tgt_d = `RCS_PC_RESET;
    end else if (ev_wake) begin
      // wake resumes after the sleep, or at the vector for irqs with global interrupts enabled
      state_d = ST_ARM;
      why_d = WHY_WAKE;
      if (ev_irq_wake && I_GLOBAL_IRQ_ENABLE) begin
        pc_tgt_d = `RCS_PC_IRQ_VEC;
      end else begin
        pc_tgt_d = I_PC + 13'h0001;
      end
    end else begin
      case (state_q)
        ST_ARM: begin
          if (why_q == WHY_BOR || (why_q == WHY_POR && powerup_timer_en)) begin
            tmr_start = 1'b1;
            state_d = ST_POWERUP_TIMER;
          end else if (crystal && (why_q == WHY_POR || why_q == WHY_WAKE)) begin
            tmr_start = 1'b1;
            tmr_len = OST_CYCLES;
            state_d = ST_OST;
          end else begin
            state_d = ST_FIN;
          end
        end
        ST_POWERUP_TIMER: begin
          // core stays held until the timer is over
          if (tmr_done) begin
            if (crystal) begin
              tmr_start = 1'b1;
              tmr_len = OST_CYCLES;
              state_d = ST_OST;
            end else begin
              state_d = ST_FIN;
            end
          end
        end
        ST_OST: begin
          if (tmr_done) begin
            state_d = ST_FIN;
          end
        end
        ST_FIN: begin
          // time-outs ran from power-on; the pin may still hold
          if (master_clear_pin_s_q) begin
            pc_load_d = 1'b1;
            state_d = ST_RUN;
          end
        end
        ST_HOLD: begin
          if (master_clear_pin_s_q) begin
            state_d = ST_ARM;
          end
        end
        ST_RUN: begin
          if (sleep_go) begin
            state_d = ST_SLEEP;
          end
        end
        ST_SLEEP: state_d = ST_SLEEP;
        default: begin
          state_d = ST_ARM;
        end
      endcase
    end
  end

  // sequencer registers; power-on reset starts with its own time-outs
  always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      state_q <= ST_ARM;
      why_q <= WHY_POR;
      pc_tgt_q <= `RCS_PC_RESET;
      O_PC_LOAD <= 1'b0;
      O_PC_VALUE <= `RCS_PC_RESET;
    end else begin
      state_q <= state_d;
      why_q <= why_d;
      pc_tgt_q <= pc_tgt_d;
      O_PC_LOAD <= pc_load_d;
      if (pc_load_d) begin
        O_PC_VALUE <= pc_tgt_q;
      end
    end
  end

  // shared delay timer
  rcs_delay #(
    .W(`RCS_TMR_W)
  ) u_delay (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_start(tmr_start),
    .i_abort(tmr_abort),
    .i_len(tmr_len),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // =====================================================
  // core control outputs
  assign O_CPU_HOLD = (state_q != ST_RUN) || tmr_busy;
  // wakes leave peripheral and interrupt request state alone
  assign O_PERIPH_RESET = (why_q != WHY_WAKE) && (state_q != ST_RUN) &&
                          (state_q != ST_SLEEP);
  assign O_ASLEEP = (state_q == ST_SLEEP);

  // =====================================================
  // power status flags
  // hardware events override a software write in the same cycle
  always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      por_flag_q <= `RCS_POR_FLAG_RST;
      bor_flag_q <= `RCS_BOR_FLAG_RST;
    end else begin
      if (wr_pwr) begin
        por_flag_q <= I_WDATA[`RCS_PWR_POR_BIT];
      end
      if (ev_bor) begin
        bor_flag_q <= 1'b0;
      end else if (wr_pwr) begin
        bor_flag_q <= I_WDATA[`RCS_PWR_BOR_BIT];
      end
    end
  end

  // =====================================================
  // time-out and power-down flags
  always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      to_flag_q <= `RCS_TO_FLAG_RST;
      pd_flag_q <= `RCS_PD_FLAG_RST;
    end else if (ev_bor) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end else if (ev_master_clear_pin_slp || ev_irq_wake || sleep_go) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b0;
    end else if (ev_wdt_rst) begin
      to_flag_q <= 1'b0;
      pd_flag_q <= 1'b1;
    end else if (ev_wdt_wake) begin
      to_flag_q <= 1'b0;
      pd_flag_q <= 1'b0;
    end
    // master clear while awake changes nothing here
  end

  assign O_TIMEOUT_FLAG = to_flag_q;
  assign O_POWERDOWN_FLAG = pd_flag_q;

  // =====================================================
  // event status, cleared by reading, and event mask
  genvar gi;
  wire [`RCS_EVT_W-1:0] evt_set;
  assign evt_set[`RCS_EVT_POR_BIT] = 1'b0;
  assign evt_set[`RCS_EVT_BOR_BIT] = ev_bor && !(state_q == ST_HOLD && why_q == WHY_BOR);
  assign evt_set[`RCS_EVT_MASTER_CLEAR_PIN_BIT] = ev_master_clear_pin || ev_master_clear_pin_slp;
  assign evt_set[`RCS_EVT_WDT_BIT] = ev_wdt_rst;
  assign evt_set[`RCS_EVT_WAKE_BIT] = ev_wake;

  // power-on bit is set by the reset itself
  generate
    for (gi = 0; gi < `RCS_EVT_W; gi = gi + 1) begin : g_evt
      always @(posedge I_MCLK) begin
        if (I_SYS_RST) begin
          evt_q[gi] <= (gi == `RCS_EVT_POR_BIT);
        end else if (evt_set[gi]) begin
          evt_q[gi] <= 1'b1;
        end else if (rd_evt) begin
          evt_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      mask_q <= `RCS_EVT_MASK_RST;
    end else if (wr_mask) begin
      mask_q <= I_WDATA[`RCS_EVT_W-1:0];
    end
  end

  assign O_IRQ = |(evt_q & mask_q);

  // =====================================================
  // read data, one cycle after the strobe
  always @(posedge I_MCLK) begin
    O_RDATA <= 8'h00;
    if (!I_SYS_RST && I_RD) begin
      if (I_ADDR == `RCS_ADDR_PWR_STAT) begin
        O_RDATA[`RCS_PWR_POR_BIT] <= por_flag_q;
        O_RDATA[`RCS_PWR_BOR_BIT] <= (HAS_BOR != 0) && bor_flag_q;
      end else if (I_ADDR == `RCS_ADDR_RST_FLAGS) begin
        O_RDATA[`RCS_FLG_TO_BIT] <= to_flag_q;
        O_RDATA[`RCS_FLG_PD_BIT] <= pd_flag_q;
      end else if (I_ADDR == `RCS_ADDR_EVT_STAT) begin
        O_RDATA[`RCS_EVT_W-1:0] <= evt_q;
      end else if (I_ADDR == `RCS_ADDR_EVT_MASK) begin
        O_RDATA[`RCS_EVT_W-1:0] <= mask_q;
      end
    end
  end

endmodule // rcs_top
